// [design/eeac_pkg.sv]
`default_nettype none
package eeac_pkg;

    // ******************************************************************
    // Register indices, byte address is four times the index
    // ******************************************************************
    localparam logic [7:0] IDX_CONTROL   = 8'h1f;
    localparam logic [7:0] IDX_DATA      = 8'h20;
    localparam logic [7:0] IDX_ADDR_LOW  = 8'h21;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h22;
    localparam logic [7:0] IDX_STATUS    = 8'h23;
    localparam logic [7:0] IDX_MASK      = 8'h24;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int CTL_READ_BIT  = 0;
    localparam int CTL_PROG_BIT  = 1;
    localparam int CTL_MPE_BIT   = 2;
    localparam int CTL_RIE_BIT   = 3;
    localparam int CTL_MODE_LSB  = 4;
    localparam int HIGH_ADDR_W   = 4;
    localparam int ST_DONE_BIT   = 0;
    localparam int ST_READ_BIT   = 1;
    localparam int ST_REFUSE_BIT = 2;
    localparam int EVENT_W       = 3;

    // ******************************************************************
    // Reset values and sizes
    // ******************************************************************
    localparam logic [7:0]  DATA_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [7:0]  ERASED     = 8'hff;
    localparam int          ARRAY_DEPTH = 4096;
    localparam int          ADDR_W      = 12;
    localparam int          PROG_CNT_W  = 18;

    // ******************************************************************
    // Timing
    // ******************************************************************
    localparam int CLK_MHZ            = 50;
    localparam int ERASE_WRITE_US_X10 = 34;
    localparam int SINGLE_OP_US_X10   = 18;
    localparam int ERASE_WRITE_CYCLES = ERASE_WRITE_US_X10 * 100 * CLK_MHZ;
    localparam int SINGLE_OP_CYCLES   = SINGLE_OP_US_X10 * 100 * CLK_MHZ;
    localparam logic [2:0] MPE_WINDOW_LAST = 3'h3;
    localparam logic [2:0] PROG_STALL      = 3'h2;
    localparam logic [2:0] READ_STALL      = 3'h4;

    // ******************************************************************
    // Modes and bus carriers
    // ******************************************************************
    typedef enum logic [1:0] {
        MODE_ERASE_WRITE = 2'h0,
        MODE_ERASE_ONLY  = 2'h1,
        MODE_WRITE_ONLY  = 2'h2,
        MODE_RESERVED    = 2'h3
    } eeac_mode_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } eeac_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } eeac_apb_rsp_s;

endpackage : eeac_pkg
`default_nettype wire

// [design/eeac_nv_array.sv]
`timescale 1ns/1ps
`default_nettype none
module eeac_nv_array #(
    parameter int DEPTH = 4096,
    parameter int AW    = 12
) (
    input  wire logic          clk_sys,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wrData,
    output logic      [7:0]    rdData
);
    // ******************************************************************
    // Nonvolatile byte storage, no reset
    // ******************************************************************
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end

    assign rdData = mem[addr];

endmodule : eeac_nv_array
`default_nettype wire

// [design/eeac_access_control.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module eeac_access_control
    import eeac_pkg::*;
#(
    parameter int ERASE_WRITE_CNT = eeac_pkg::ERASE_WRITE_CYCLES,
    parameter int SINGLE_OP_CNT   = eeac_pkg::SINGLE_OP_CYCLES
) (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic                   porN,
    input  wire eeac_pkg::eeac_apb_req_s apbReq,
    output eeac_pkg::eeac_apb_rsp_s      apbRsp,
    input  wire logic                   cpuGlobalIrqEn,
    input  wire logic                   flashSelfprogEnable,
    output logic                        cpuStall,
    output logic                        readyIrq,
    output logic                        irq
);
    import eeac_pkg::*;

    // ******************************************************************
    // Declarations
    // ******************************************************************
    logic [ADDR_W-1:0]     nvAddress_ff;
    logic [7:0]            nvData_ff;
    eeac_mode_e            progModeField_ff;
    logic                  readyIrqEnable_ff;
    logic                  masterProgEnable_ff;
    logic [2:0]            mpeCnt_ff;
    logic                  progEnable_ff;
    logic                  readStrobe_ff;
    logic [PROG_CNT_W-1:0] progCnt_ff;
    logic [7:0]            progData_ff;
    logic [2:0]            stallCnt_ff;
    logic [EVENT_W-1:0]    status_ff;
    logic [EVENT_W-1:0]    mask_ff;
    logic [31:0]           prdata_ff;
    logic [31:0]           rdMux;
    logic [7:0]            arrRd;
    logic [7:0]            arrWrData;
    logic [EVENT_W-1:0]    events;
    eeac_mode_e            nxt_mode;
    logic                  sysRst;
    logic                  access;
    logic                  wrCtl;
    logic                  mapped;
    logic                  progStart;
    logic                  progRefused;
    logic                  progDone;
    logic                  rdStart;

    // ******************************************************************
    // Decode helpers
    // ******************************************************************
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction : hit

    function automatic logic [PROG_CNT_W-1:0] opCycles(input eeac_mode_e m);
        if (m == MODE_ERASE_WRITE) begin
            return PROG_CNT_W'(ERASE_WRITE_CNT - 1);
        end
        return PROG_CNT_W'(SINGLE_OP_CNT - 1);
    endfunction : opCycles

    // ******************************************************************
    // APB slave
    // ******************************************************************
    assign sysRst = !nrst || !porN;
    assign access = apbReq.psel && apbReq.penable && apbRsp.pready;
    assign wrCtl  = access && apbReq.pwrite && hit(apbReq.paddr, IDX_CONTROL);
    assign mapped = hit(apbReq.paddr, IDX_CONTROL) || hit(apbReq.paddr, IDX_DATA)
                 || hit(apbReq.paddr, IDX_ADDR_LOW) || hit(apbReq.paddr, IDX_ADDR_HIGH)
                 || hit(apbReq.paddr, IDX_STATUS) || hit(apbReq.paddr, IDX_MASK);

    always_comb begin
        rdMux = 32'h0000_0000;
        if (hit(apbReq.paddr, IDX_CONTROL)) begin
            rdMux = {26'h0, progModeField_ff, readyIrqEnable_ff, masterProgEnable_ff,
                     progEnable_ff, readStrobe_ff};
        end else if (hit(apbReq.paddr, IDX_DATA)) begin
            rdMux = {24'h0, nvData_ff};
        end else if (hit(apbReq.paddr, IDX_ADDR_LOW)) begin
            rdMux = {24'h0, nvAddress_ff[7:0]};
        end else if (hit(apbReq.paddr, IDX_ADDR_HIGH)) begin
            rdMux = {28'h0, nvAddress_ff[ADDR_W-1:8]};
        end else if (hit(apbReq.paddr, IDX_STATUS)) begin
            rdMux = {29'h0, status_ff};
        end else if (hit(apbReq.paddr, IDX_MASK)) begin
            rdMux = {29'h0, mask_ff};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apbReq.psel) begin
            prdata_ff <= rdMux;
        end
    end

    // Stall holds the bus off until the processor may go on
    assign apbRsp.pready  = (stallCnt_ff == 3'h0);
    assign apbRsp.prdata  = prdata_ff;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;

    // ******************************************************************
    // Address and data registers
    // ******************************************************************
    always_ff @(posedge clk_sys) begin
        if (!porN || (!nrst && !progEnable_ff)) begin
            nvAddress_ff <= ADDR_RESET;
        end else if (access && apbReq.pwrite && !progEnable_ff) begin
            if (hit(apbReq.paddr, IDX_ADDR_LOW)) begin
                nvAddress_ff[7:0] <= apbReq.pwdata[7:0];
            end
            if (hit(apbReq.paddr, IDX_ADDR_HIGH)) begin
                nvAddress_ff[ADDR_W-1:8] <= apbReq.pwdata[HIGH_ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            nvData_ff <= DATA_RESET;
        end else if (rdStart) begin
            nvData_ff <= arrRd;
        end else if (access && apbReq.pwrite && hit(apbReq.paddr, IDX_DATA)) begin
            nvData_ff <= apbReq.pwdata[7:0];
        end
    end

    // ******************************************************************
    // Control register
    // ******************************************************************
    assign nxt_mode = progEnable_ff ? progModeField_ff
                                    : eeac_mode_e'(apbReq.pwdata[CTL_MODE_LSB +: 2]);
    assign rdStart  = wrCtl && apbReq.pwdata[CTL_READ_BIT] && !progEnable_ff;
    assign progRefused = wrCtl && apbReq.pwdata[CTL_PROG_BIT] && !progEnable_ff
                      && (!masterProgEnable_ff || flashSelfprogEnable
                          || nxt_mode == MODE_RESERVED);
    assign progStart = wrCtl && apbReq.pwdata[CTL_PROG_BIT] && !progEnable_ff
                    && masterProgEnable_ff
                    && !flashSelfprogEnable
                    && nxt_mode != MODE_RESERVED;
    assign progDone  = progEnable_ff && (progCnt_ff == '0);

    always_ff @(posedge clk_sys) begin
        if (!porN || (!nrst && !progEnable_ff)) begin
            progModeField_ff <= MODE_ERASE_WRITE;
        end else if (wrCtl) begin
            progModeField_ff <= nxt_mode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            readyIrqEnable_ff <= 1'b0;
        end else if (wrCtl) begin
            readyIrqEnable_ff <= apbReq.pwdata[CTL_RIE_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            masterProgEnable_ff <= 1'b0;
            mpeCnt_ff           <= 3'h0;
        end else if (wrCtl && apbReq.pwdata[CTL_MPE_BIT] && !masterProgEnable_ff) begin
            masterProgEnable_ff <= 1'b1;
            mpeCnt_ff           <= MPE_WINDOW_LAST;
        end else if (masterProgEnable_ff) begin
            if (mpeCnt_ff == 3'h0) begin
                masterProgEnable_ff <= 1'b0;
            end else begin
                mpeCnt_ff <= mpeCnt_ff - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            readStrobe_ff <= 1'b0;
        end else begin
            readStrobe_ff <= rdStart;
        end
    end

    // ******************************************************************
    // Programming engine, survives nrst while busy, cleared only by porN
    // ******************************************************************
    always_ff @(posedge clk_sys) begin
        if (!porN) begin
            progEnable_ff <= 1'b0;
            progCnt_ff    <= '0;
            progData_ff   <= DATA_RESET;
        end else if (progStart) begin
            progEnable_ff <= 1'b1;
            progCnt_ff    <= opCycles(nxt_mode);
            progData_ff   <= nvData_ff;
        end else if (progDone) begin
            progEnable_ff <= 1'b0;
        end else if (progEnable_ff) begin
            progCnt_ff <= progCnt_ff - PROG_CNT_W'(1);
        end
    end

    always_comb begin
        unique case (progModeField_ff)
            MODE_ERASE_WRITE: arrWrData = progData_ff;
            MODE_ERASE_ONLY:  arrWrData = ERASED;
            MODE_WRITE_ONLY:  arrWrData = arrRd & progData_ff;
            MODE_RESERVED:    arrWrData = arrRd;
        endcase
    end

    eeac_nv_array #(
        .DEPTH (ARRAY_DEPTH),
        .AW    (ADDR_W)
    ) u_array (
        .clk_sys (clk_sys),
        .wrEn    (progDone),
        .addr    (nvAddress_ff),
        .wrData  (arrWrData),
        .rdData  (arrRd)
    );

    // ******************************************************************
    // Processor stall
    // ******************************************************************
    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            stallCnt_ff <= 3'h0;
        end else if (progStart) begin
            stallCnt_ff <= PROG_STALL;
        end else if (rdStart) begin
            stallCnt_ff <= READ_STALL;
        end else if (stallCnt_ff != 3'h0) begin
            stallCnt_ff <= stallCnt_ff - 3'h1;
        end
    end

    assign cpuStall = (stallCnt_ff != 3'h0);

    // ******************************************************************
    // Interrupts
    // ******************************************************************
    assign readyIrq = readyIrqEnable_ff && cpuGlobalIrqEn && !progEnable_ff;
    assign events   = {progRefused, rdStart, progDone};

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            status_ff <= '0;
        end else if (access && apbReq.pwrite && hit(apbReq.paddr, IDX_STATUS)) begin
            status_ff <= (status_ff & ~apbReq.pwdata[EVENT_W-1:0]) | events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sysRst) begin
            mask_ff <= '0;
        end else if (access && apbReq.pwrite && hit(apbReq.paddr, IDX_MASK)) begin
            mask_ff <= apbReq.pwdata[EVENT_W-1:0];
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ******************************************************************
    // Assertions
    // ******************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sysRst);

    hi_addr_zero_a: assert property (access && !apbReq.pwrite
        && hit(apbReq.paddr, IDX_ADDR_HIGH) |-> apbRsp.prdata[31:4] == 28'h0)
        else $error("high address upper bits not zero");
    ctl_top_zero_a: assert property (access && !apbReq.pwrite
        && hit(apbReq.paddr, IDX_CONTROL) |-> apbRsp.prdata[31:6] == 26'h0)
        else $error("control upper bits not zero");
    mode_locked_a: assert property (progEnable_ff && $past(progEnable_ff)
        |-> $stable(progModeField_ff))
        else $error("mode changed while programming");
    mode_reset_a: assert property (@(posedge clk_sys) disable iff (!porN)
        $past(!nrst) && !$past(progEnable_ff) |-> progModeField_ff == MODE_ERASE_WRITE)
        else $error("mode not cleared by reset");
    mpe_window_a: assert property ($rose(masterProgEnable_ff)
        |-> masterProgEnable_ff[*4] ##1 !masterProgEnable_ff)
        else $error("master enable window not four cycles");
    start_mpe_a: assert property ($rose(progEnable_ff)
        |-> $past(masterProgEnable_ff) && !$past(flashSelfprogEnable))
        else $error("programming started without master enable");
    ew_time_a: assert property ($rose(progEnable_ff)
        && progModeField_ff == MODE_ERASE_WRITE
        |-> progCnt_ff == PROG_CNT_W'(ERASE_WRITE_CNT - 1))
        else $error("erase-write time wrong");
    prog_hold_a: assert property (progEnable_ff && progCnt_ff != '0
        |=> progEnable_ff)
        else $error("program enable dropped early");
    prog_end_a: assert property (progDone |=> !progEnable_ff)
        else $error("program enable not cleared");
    stall_prog_a: assert property ($rose(progEnable_ff)
        |-> cpuStall[*2] ##1 !cpuStall)
        else $error("program stall not two cycles");
    stall_read_a: assert property (rdStart
        |=> cpuStall[*4] ##1 !cpuStall)
        else $error("read stall not four cycles");
    read_data_a: assert property (rdStart |=> nvData_ff == $past(arrRd)
        && readStrobe_ff ##1 !readStrobe_ff)
        else $error("read data or strobe wrong");
    addr_hold_a: assert property (progEnable_ff && $past(progEnable_ff)
        |-> $stable(nvAddress_ff))
        else $error("address changed while programming");
    ready_irq_a: assert property (readyIrq
        |-> !progEnable_ff && readyIrqEnable_ff && cpuGlobalIrqEn)
        else $error("ready interrupt wrong");

    prog_done_c: cover property (progDone ##1 readyIrq);
    read_c: cover property (rdStart ##5 !cpuStall);
    refuse_c: cover property (progRefused);
    mpe_expire_c: cover property ($fell(masterProgEnable_ff) && !progEnable_ff);

endmodule : eeac_access_control
`default_nettype wire

// [bench/test_eeprom_access_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_access_control;
    import eeac_pkg::*;
    localparam int EW = 40;
    localparam int SO = 24;
    typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} eeac_row_s;
    logic                    clk_sys;
    logic                    nrst;
    logic                    porN;
    logic                    cpuGlobalIrqEn;
    logic                    flashSelfprogEnable;
    eeac_pkg::eeac_apb_req_s apbReq;
    eeac_pkg::eeac_apb_rsp_s apbRsp;
    logic                    cpuStall;
    logic                    readyIrq;
    logic                    irq;
    logic [31:0]             rd;
    logic                    err;
    int                      num_errors;
    int                      total_checks;
    int                      stallCnt;
    int                      busyCnt;
    int                      s0;
    int                      b0;
    eeac_row_s               rows [6];
    logic [1:0]              mds [3];
    logic [7:0]              dats [3];
    logic [7:0]              exps [3];
    int                      durs [3];
    logic [7:0]              pre [3];
    logic [7:0]              st [3];

    eeac_access_control #(.ERASE_WRITE_CNT(EW), .SINGLE_OP_CNT(SO)) DUT (
        .clk_sys             (clk_sys),
        .nrst                (nrst),
        .porN                (porN),
        .apbReq              (apbReq),
        .apbRsp              (apbRsp),
        .cpuGlobalIrqEn      (cpuGlobalIrqEn),
        .flashSelfprogEnable (flashSelfprogEnable),
        .cpuStall            (cpuStall),
        .readyIrq            (readyIrq),
        .irq                 (irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (cpuStall === 1'b1) begin
            stallCnt <= stallCnt + 1;
        end
        if (readyIrq === 1'b0) begin
            busyCnt <= busyCnt + 1;
        end
    end

    // ******************************************************************
    // Bus and check tasks
    // ******************************************************************
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
        total_checks++;
        if (seen !== ex) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, ex, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= {2'b00, idx, 2'b00};
        apbReq.pwdata  <= wd;
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        @(posedge clk_sys);
        while (apbRsp.pready !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            finish_test();
        end
        rd             = apbRsp.prdata;
        err            = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wait_idle;
        int n;
        n = 0;
        rd = 32'h2;
        while (rd[1] !== 1'b0 && n < 40) begin
            apb(1'b0, IDX_CONTROL, 32'h0);
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            finish_test();
        end
    endtask : wait_idle

    task automatic prog(input logic [1:0] md, input logic [7:0] dat);
        cpuGlobalIrqEn <= 1'b0;
        apb(1'b1, IDX_ADDR_LOW, 32'h23);
        apb(1'b1, IDX_ADDR_HIGH, 32'h01);
        apb(1'b1, IDX_DATA, {24'h0, dat});
        apb(1'b1, IDX_CONTROL, {26'h0, md, 4'hc});
        apb(1'b1, IDX_CONTROL, {26'h0, md, 4'ha});
        s0 = stallCnt;
        b0 = busyCnt;
        cpuGlobalIrqEn <= 1'b1;
    endtask : prog

    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial begin
        apbReq = '0;
        nrst = 1'b0;
        porN = 1'b0;
        cpuGlobalIrqEn = 1'b1;
        flashSelfprogEnable = 1'b0;
        num_errors = 0;
        total_checks = 0;
        stallCnt = 0;
        busyCnt = 0;
        rows = '{{IDX_DATA, 8'ha5, 8'ha5}, {IDX_ADDR_LOW, 8'h3c, 8'h3c},
                 {IDX_ADDR_HIGH, 8'hff, 8'h0f}, {IDX_MASK, 8'h07, 8'h07},
                 {IDX_CONTROL, 8'hc8, 8'h08}, {8'h3f, 8'h12, 8'h00}};
        mds  = '{2'h0, 2'h1, 2'h2};
        dats = '{8'h5a, 8'h00, 8'h0f};
        exps = '{8'h5a, 8'hff, 8'h0f};
        durs = '{EW, SO, SO};
        pre  = '{8'h08, 8'h0c, 8'h3c};
        st   = '{8'h0a, 8'h0a, 8'h3a};
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        porN <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, IDX_DATA, 32'h0);
        check("data reset", rd, {24'h0, DATA_RESET});
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("control reset", rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, {24'hffffff, rows[i].wd});
            apb(1'b0, rows[i].idx, 32'h0);
            check("reg read", rd, {24'h0, rows[i].ex});
            check("slave error", err, rows[i].idx == 8'h3f);
        end
        for (int i = 0; i < 3; i++) begin
            prog(mds[i], dats[i]);
            wait_idle();
            check("busy cycles", busyCnt - b0, durs[i]);
            check("prog stall", stallCnt - s0, 2);
            s0 = stallCnt;
            apb(1'b1, IDX_CONTROL, 32'h09);
            apb(1'b0, IDX_DATA, 32'h0);
            check("read data", rd, {24'h0, exps[i]});
            check("read stall", stallCnt - s0, 4);
            apb(1'b0, IDX_CONTROL, 32'h0);
            check("strobe clear", rd, 32'h08);
        end
        apb(1'b0, IDX_STATUS, 32'h0);
        check("status done", rd, 32'h03);
        check("irq set", irq, 1'b1);
        apb(1'b1, IDX_STATUS, 32'h03);
        check("irq clear", irq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            flashSelfprogEnable <= (i == 1);
            apb(1'b1, IDX_CONTROL, {24'h0, pre[i]});
            apb(1'b1, IDX_CONTROL, {24'h0, st[i]});
            apb(1'b0, IDX_CONTROL, 32'h0);
            check("no start", rd[1], 1'b0);
            apb(1'b0, IDX_STATUS, 32'h0);
            check("refused", rd, 32'h04);
            check("irq refused", irq, 1'b1);
            apb(1'b1, IDX_STATUS, 32'h04);
        end
        flashSelfprogEnable <= 1'b0;
        apb(1'b1, IDX_CONTROL, 32'h0c);
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("window open", rd, 32'h0c);
        repeat (4) @(posedge clk_sys);
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("window shut", rd, 32'h08);
        apb(1'b1, IDX_MASK, 32'h0);
        apb(1'b1, IDX_CONTROL, 32'h0a);
        check("irq masked", irq, 1'b0);
        cpuGlobalIrqEn <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        check("ready gated", readyIrq, 1'b0);
        cpuGlobalIrqEn <= 1'b1;
        prog(2'h2, 8'h00);
        apb(1'b1, IDX_ADDR_LOW, 32'h77);
        apb(1'b0, IDX_ADDR_LOW, 32'h0);
        check("addr frozen", rd, 32'h23);
        apb(1'b1, IDX_CONTROL, 32'h3a);
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("mode frozen", rd, 32'h2a);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("mode kept", rd, 32'h22);
        wait_idle();
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, IDX_CONTROL, 32'h0);
        check("mode cleared", rd, 32'h00);
        finish_test();
    end
endmodule : test_eeprom_access_control
`default_nettype wire
